// File: verilog/cldp_config.sv
/*
  apb slave holding closed_loop_config_one and a status word, plus the
  decoded controls it feeds to the motor-control core.
  every control output is a flip-flop loaded from the decode of the next
  register image, so it moves on the same edge as the register itself.
  refused accesses (status write, unmapped address) leave cfg_reg and the controls alone; only err_reg and, on a read, rdata_reg load.
  assumes a single apb master on pclk; pready is always high.
  assumes cldp_pkg and cldp_defs.svh are compiled ahead of this file.
*/
`timescale 1ns/1ns
`include "cldp_defs.svh"
module cldp_config (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output cldp_pkg::cldp_rate_t      decel_rate_eff,
  output logic                      decel_limit_off,
  output logic                      decel_from_accel,
  output cldp_pkg::cldp_freq_t      switching_freq_sel,
  output logic      [6:0]           switching_freq_khz,
  output logic                      switching_freq_bad,
  output cldp_pkg::cldp_svm_t       svm_mode,
  output logic                      surge_protect_enable,
  output logic                      dead_time_comp_enable
);
  import cldp_pkg::*;

  // ----------------------------------------
  // code to khz lookup
  // ----------------------------------------
  function automatic logic [6:0] freq_khz(input cldp_freq_t code);
    case (code)
      4'h0:    freq_khz = 7'h05;
      4'h1:    freq_khz = 7'h0a;
      4'h2:    freq_khz = 7'h10;
      4'h3:    freq_khz = 7'h14;
      4'h4:    freq_khz = 7'h19;
      4'h5:    freq_khz = 7'h20;
      4'h6:    freq_khz = 7'h28;
      4'h7:    freq_khz = 7'h30;
      4'h8:    freq_khz = 7'h32;
      4'h9:    freq_khz = 7'h40;
      4'ha:    freq_khz = 7'h50;
      // codes above ah have no frequency
      default: freq_khz = 7'h00;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic [31:0] stat_word;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_cfg;
  logic        hit_stat;

  cldp_rate_t  dec_field;
  cldp_rate_t  acc_field;
  logic        src_sel;
  cldp_freq_t  freq_field;

  // ----------------------------------------
  // bus phases and address decode
  // ----------------------------------------
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && !penable && !pwrite;

  always_comb begin
    hit_cfg  = 1'b0;
    hit_stat = 1'b0;
    if (paddr == `CLDP_CFG_OFFSET) begin
      hit_cfg = 1'b1;
    end else if (paddr == `CLDP_STAT_OFFSET) begin
      hit_stat = 1'b1;
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign dec_field  = cfg_next[`CLDP_DEC_MSB:`CLDP_DEC_LSB];
  assign acc_field  = cfg_next[`CLDP_ACC_MSB:`CLDP_ACC_LSB];
  assign src_sel    = cfg_next[`CLDP_SRC_BIT];
  assign freq_field = cfg_next[`CLDP_FREQ_MSB:`CLDP_FREQ_LSB];

  // ----------------------------------------
  // configuration word
  // ----------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_acc && hit_cfg) begin
      cfg_next = merge(cfg_reg, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CLDP_CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------
  // slave error, judged in the setup cycle
  // ----------------------------------------
  always_comb begin
    err_next = 1'b0;
    if (psel && !penable) begin
      if (hit_cfg) begin
        err_next = 1'b0;
      end else if (hit_stat) begin
        err_next = pwrite;
      end else begin
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // ----------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_acc) begin
      if (hit_cfg) begin
        rdata_next = cfg_reg;
      end else if (hit_stat) begin
        rdata_next = stat_word;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // decoded control outputs
  // ----------------------------------------
  cldp_rate_t  rate_pick;
  cldp_rate_t  rate_eff_reg;
  cldp_rate_t  rate_eff_next;
  logic        limit_off_reg;
  logic        limit_off_next;
  logic        from_accel_reg;
  logic        from_accel_next;
  logic        surge_reg;
  logic        surge_next;
  cldp_freq_t  freq_sel_reg;
  cldp_freq_t  freq_sel_next;
  logic [6:0]  freq_khz_reg;
  logic [6:0]  freq_khz_next;
  logic        freq_bad_reg;
  logic        freq_bad_next;
  cldp_svm_t   svm_reg;
  cldp_svm_t   svm_next;
  logic        dtc_reg;
  logic        dtc_next;

  // ----------------------------------------
  // surge protection enable
  // ----------------------------------------
  always_comb begin
    surge_next = cfg_next[`CLDP_SURGE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      surge_reg <= 1'b0;
    end else begin
      surge_reg <= surge_next;
    end
  end

  // ----------------------------------------
  // effective deceleration
  // ----------------------------------------
  always_comb begin
    rate_pick = dec_field;
    if (src_sel) begin
      rate_pick = acc_field;
    end
    rate_eff_next   = rate_pick;
    limit_off_next  = 1'b0;
    from_accel_next = 1'b0;
    if (surge_next) begin
      rate_eff_next = `CLDP_RATE_BLOCKED;
    end else begin
      limit_off_next  = rate_pick == `CLDP_RATE_NOLIMIT;
      from_accel_next = src_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_eff_reg   <= `CLDP_RATE_RESET;
      limit_off_reg  <= 1'b0;
      from_accel_reg <= 1'b0;
    end else begin
      rate_eff_reg   <= rate_eff_next;
      limit_off_reg  <= limit_off_next;
      from_accel_reg <= from_accel_next;
    end
  end

  // ----------------------------------------
  // pwm frequency and modulation
  // ----------------------------------------
  always_comb begin
    freq_sel_next = freq_field;
    freq_khz_next = freq_khz(freq_field);
    freq_bad_next = freq_field > `CLDP_FREQ_MAX_CODE;
    svm_next      = CLDP_SVM_CONT;
    if (cfg_next[`CLDP_MODE_BIT]) begin
      svm_next = CLDP_SVM_DISC;
    end
    dtc_next      = cfg_next[`CLDP_DTC_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_sel_reg <= `CLDP_FREQ_RESET;
      freq_khz_reg <= `CLDP_KHZ_RESET;
      freq_bad_reg <= 1'b0;
      svm_reg      <= CLDP_SVM_CONT;
      dtc_reg      <= 1'b0;
    end else begin
      freq_sel_reg <= freq_sel_next;
      freq_khz_reg <= freq_khz_next;
      freq_bad_reg <= freq_bad_next;
      svm_reg      <= svm_next;
      dtc_reg      <= dtc_next;
    end
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  assign surge_protect_enable  = surge_reg;
  assign decel_rate_eff        = rate_eff_reg;
  assign decel_limit_off       = limit_off_reg;
  assign decel_from_accel      = from_accel_reg;
  assign switching_freq_sel    = freq_sel_reg;
  assign switching_freq_khz    = freq_khz_reg;
  assign switching_freq_bad    = freq_bad_reg;
  assign svm_mode              = svm_reg;
  assign dead_time_comp_enable = dtc_reg;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`CLDP_STAT_RATE_LSB +: 5] = decel_rate_eff;
    stat_word[`CLDP_STAT_FREQ_LSB +: 7] = switching_freq_khz;
    stat_word[`CLDP_STAT_FLAG_LSB]      = decel_limit_off;
    stat_word[`CLDP_STAT_FLAG_LSB + 1]  = decel_from_accel;
    stat_word[`CLDP_STAT_FLAG_LSB + 2]  = switching_freq_bad;
    stat_word[`CLDP_STAT_FLAG_LSB + 3]  = surge_protect_enable;
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;

endmodule

// File: verilog/cldp_defs.svh
/*
  constants for the closed-loop decel / pwm configuration register bank.
  assumes inclusion by bare name from the design file.
*/
// Notes on behaviour
// - five-bit decel rate field, resets zero, 1fh unlimited
// - decel rate ignored while surge protection enabled
// - decel rate used only when source select zero
// - frequency select codes 0h-ah map to khz values
// - modulation bit zero continuous, one discontinuous svm
// - surge protection enable bit, resets zero
// - dead-time compensation only while enable bit set
// - source select one uses acceleration rate instead
`ifndef CLDP_DEFS_SVH
`define CLDP_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CLDP_CFG_OFFSET     12'h000
`define CLDP_STAT_OFFSET    12'h004
`define CLDP_CFG_RESET      32'h0000_0000
// ----------------------------------------
// field positions of closed_loop_config_one
// ----------------------------------------
`define CLDP_RSVD_HI_MSB    31
`define CLDP_RSVD_HI_LSB    30
`define CLDP_UPPER_MSB      29
`define CLDP_UPPER_LSB      19
`define CLDP_ACC_MSB        18
`define CLDP_ACC_LSB        14
`define CLDP_SRC_BIT        13
`define CLDP_DEC_MSB        12
`define CLDP_DEC_LSB        8
`define CLDP_FREQ_MSB       7
`define CLDP_FREQ_LSB       4
`define CLDP_MODE_BIT       14
`define CLDP_SURGE_BIT      3
`define CLDP_DTC_BIT        2
`define CLDP_RSVD_BIT       1
// ----------------------------------------
// codes and status layout
// ----------------------------------------
`define CLDP_RATE_NOLIMIT   5'h1f
`define CLDP_FREQ_MAX_CODE  4'ha
`define CLDP_RATE_BLOCKED   5'h00
`define CLDP_RATE_RESET     5'h00
`define CLDP_FREQ_RESET     4'h0
`define CLDP_KHZ_RESET      7'h05
`define CLDP_STAT_RATE_LSB  0
`define CLDP_STAT_FREQ_LSB  8
`define CLDP_STAT_FLAG_LSB  16
`endif

// File: verilog/cldp_pkg.sv
/*
  types for the closed-loop decel / pwm configuration register bank.
  assumes cldp_defs.svh is visible on the include path.
*/
package cldp_pkg;
  typedef enum logic {
    CLDP_SVM_CONT,
    CLDP_SVM_DISC
  } cldp_svm_t;
  typedef logic [4:0] cldp_rate_t;
  typedef logic [3:0] cldp_freq_t;
endpackage

// File: verif/cldp_config_props.sv
/* checker on the cldp_config ports.
   assumes a bind from the bench top. */
`timescale 1ns/1ns
module cldp_config_props (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic                 pslverr,
  input wire cldp_pkg::cldp_rate_t decel_rate_eff,
  input wire logic                 decel_limit_off,
  input wire logic                 decel_from_accel,
  input wire logic                 switching_freq_bad,
  input wire logic [6:0]           switching_freq_khz,
  input wire cldp_pkg::cldp_freq_t switching_freq_sel,
  input wire logic                 surge_protect_enable,
  input wire cldp_pkg::cldp_svm_t  svm_mode,
  input wire logic                 dead_time_comp_enable
);
  import cldp_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  property p_srg;
    surge_protect_enable |-> decel_rate_eff == 5'h00 && !decel_from_accel;
  endproperty
  a_srg: assert property (p_srg) else $error("decel not blocked");
  property p_lim;
    decel_limit_off == (decel_rate_eff == 5'h1f && !surge_protect_enable);
  endproperty
  a_lim: assert property (p_lim) else $error("limit flag wrong");
  property p_acc; decel_from_accel |-> !surge_protect_enable; endproperty
  a_acc: assert property (p_acc) else $error("accel source wrong");
  property p_bad;
    switching_freq_sel <= 4'ha |-> !switching_freq_bad &&
      switching_freq_khz inside {7'h05, 7'h0a, 7'h10, 7'h14, 7'h19, 7'h20,
                                 7'h28, 7'h30, 7'h32, 7'h40, 7'h50};
  endproperty
  a_bad: assert property (p_bad) else $error("legal code wrong");
  property p_khz; !switching_freq_bad |-> switching_freq_khz >= 7'h05; endproperty
  a_khz: assert property (p_khz) else $error("khz out of range");
  property p_err;
    acc && (paddr > 12'h004 || pwrite && paddr == 12'h004) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ro;
    acc && pwrite && paddr == 12'h004 |=> $stable(surge_protect_enable);
  endproperty
  a_ro: assert property (p_ro) else $error("status write took");
  property p_hold;
    !(acc && pwrite) |=> $stable(svm_mode) && $stable(dead_time_comp_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("control moved");
  property p_rst;
    $rose(presetn) |-> !surge_protect_enable && svm_mode == CLDP_SVM_CONT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  c_srg: cover property (surge_protect_enable);
  c_disc: cover property (svm_mode == CLDP_SVM_DISC);
  c_acc: cover property (decel_from_accel);
endmodule

// File: verif/cldp_config_tb_top.sv
/* bench for cldp_config: apb driver, queued read checks.
   assumes design and checker compiled first. */
`timescale 1ns/1ns
module cldp_config_tb_top;
  import cldp_pkg::*;
  // ----------------------------------------
  // signals and helpers
  // ----------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, cfg = 0, d;
  logic [3:0]  pstrb = 0, s;
  logic        pready, pslverr, decel_limit_off, decel_from_accel;
  logic        switching_freq_bad, surge_protect_enable, dead_time_comp_enable;
  cldp_rate_t  decel_rate_eff;
  cldp_freq_t  switching_freq_sel;
  cldp_svm_t   svm_mode;
  logic [6:0]  switching_freq_khz;
  logic [31:0] q[$];
  int          miscompares = 0, checks = 0;
  integer      seed = 25187;
  logic [6:0]  kt [12] = '{7'h05, 7'h0a, 7'h10, 7'h14, 7'h19, 7'h20,
                           7'h28, 7'h30, 7'h32, 7'h40, 7'h50, 7'h00};
  always #50 pclk = ~pclk;
  cldp_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .decel_rate_eff(decel_rate_eff), .decel_limit_off(decel_limit_off),
    .decel_from_accel(decel_from_accel),
    .switching_freq_sel(switching_freq_sel),
    .switching_freq_khz(switching_freq_khz),
    .switching_freq_bad(switching_freq_bad), .svm_mode(svm_mode),
    .surge_protect_enable(surge_protect_enable),
    .dead_time_comp_enable(dead_time_comp_enable));
  function automatic logic [31:0] stat(logic [31:0] c);
    logic [4:0] r;
    logic       b;
    r = c[3] ? 5'h00 : c[13] ? c[18:14] : c[12:8];
    b = c[7:4] > 4'ha;
    return {12'h000, c[3], b, c[13] & ~c[3], r == 5'h1f & ~c[3], 1'b0,
            kt[b ? 4'hb : c[7:4]], 3'h0, r};
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] dd, logic [3:0] st);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(logic [11:0] a, logic [31:0] e);
    q.push_back(e);
    apb(0, a, 32'h0, 4'h0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk("prdata", q.pop_front(), prdata);
  end
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 32'h0);
    rd(12'h004, stat(32'h0));
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      d[7:4] = $unsigned($random(seed)) % 11;
      if (i % 8 == 0) d[12:8] = 5'h1f;
      s = $random(seed);
      for (int b = 0; b < 4; b++) if (s[b]) cfg[8*b+:8] = d[8*b+:8];
      apb(1, 12'h000, d, s);
      rd(12'h000, cfg);
      rd(12'h004, stat(cfg));
      chk("svm_dtc", {svm_mode, dead_time_comp_enable}, {cfg[14], cfg[2]});
      chk("freq_sel", cfg[7:4], switching_freq_sel);
    end
    apb(1, 12'h004, ~cfg, 4'hf);
    rd(12'h000, cfg);
    rd(12'h008, 32'h0);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 32'h0);
    repeat (2) @(posedge pclk);
    final_report;
  end
endmodule
bind cldp_config cldp_config_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pslverr(pslverr), .decel_rate_eff(decel_rate_eff),
  .decel_limit_off(decel_limit_off), .decel_from_accel(decel_from_accel),
  .switching_freq_bad(switching_freq_bad),
  .switching_freq_khz(switching_freq_khz),
  .switching_freq_sel(switching_freq_sel),
  .surge_protect_enable(surge_protect_enable), .svm_mode(svm_mode),
  .dead_time_comp_enable(dead_time_comp_enable));
